// ### src/pslpg_pkg.sv
/*
 * Package for the protocol status LED pattern generator: register map,
 * field positions, reset values, pattern timing and pattern functions.
 * Assumes a single 200 MHz clock and a millisecond tick derived from it.
 */
package pslpg_pkg;

    // Clock and timebase
    localparam int unsigned CLK_HZ         = 200_000_000;
    localparam int unsigned TICK_MS        = 1;
    localparam int unsigned PRESC_W        = 18;
    localparam logic [PRESC_W-1:0] MS_TICK_CYCLES = PRESC_W'(CLK_HZ / 1000 * TICK_MS);

    // Pattern times in milliseconds
    localparam int unsigned PH_W           = 11;
    localparam logic [PH_W-1:0] T_FLASH_1HZ_MS = 11'd500;
    localparam logic [PH_W-1:0] T_FLASH_5HZ_MS = 11'd100;
    localparam logic [PH_W-1:0] T_SYS_ON_MS    = 11'd125;
    localparam logic [PH_W-1:0] T_SYS_OFF_MS   = 11'd375;
    localparam logic [PH_W-1:0] T_SHORT_MS     = 11'd200;
    localparam logic [PH_W-1:0] T_LONG_OFF_MS  = 11'd1000;
    localparam logic [PH_W-1:0] T_FLICKER_MS   = 11'd50;
    localparam logic [PH_W-1:0] T_BLINK_MS     = 11'd200;

    // Activity flicker counter
    localparam int unsigned ACT_W          = 6;
    localparam logic [ACT_W-1:0] T_ACT_MS  = 6'd50;

    // Register bus
    localparam int unsigned ADDR_W         = 4;
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK     = 32'h0000_173d;

    // Control fields
    localparam int unsigned CTRL_MODE      = 0;
    localparam int unsigned CTRL_RUN_LSB   = 2;
    localparam int unsigned CTRL_SYSERR    = 4;
    localparam int unsigned CTRL_COMERR    = 5;
    localparam int unsigned CTRL_NODE_LSB  = 8;
    localparam int unsigned CTRL_NODEERR   = 12;

    // Modbus server task states
    localparam logic [1:0] RUN_NOT_READY = 2'h0;
    localparam logic [1:0] RUN_NOT_CFG   = 2'h1;
    localparam logic [1:0] RUN_WAITING   = 2'h2;
    localparam logic [1:0] RUN_CONNECTED = 2'h3;

    // Controlled node states
    localparam logic [2:0] NODE_INIT     = 3'h0;
    localparam logic [2:0] NODE_BASIC    = 3'h1;
    localparam logic [2:0] NODE_PREOP1   = 3'h2;
    localparam logic [2:0] NODE_PREOP2   = 3'h3;
    localparam logic [2:0] NODE_RTO      = 3'h4;
    localparam logic [2:0] NODE_OPER     = 3'h5;
    localparam logic [2:0] NODE_STOPPED  = 3'h6;

    typedef enum logic [3:0] {
        PAT_OFF, PAT_ON, PAT_F1HZ, PAT_F5HZ, PAT_F2HZ,
        PAT_TRIPLE, PAT_DOUBLE, PAT_SINGLE, PAT_FLICKER, PAT_BLINK
    } pslpg_pat_t;

    function automatic logic [PH_W-1:0] pat_period(input pslpg_pat_t p);
        unique case (p)
            PAT_F1HZ:    pat_period = 11'(2 * T_FLASH_1HZ_MS);
            PAT_F5HZ:    pat_period = 11'(2 * T_FLASH_5HZ_MS);
            PAT_F2HZ:    pat_period = 11'(T_SYS_ON_MS + T_SYS_OFF_MS);
            PAT_TRIPLE:  pat_period = 11'(5 * T_SHORT_MS + T_LONG_OFF_MS);
            PAT_DOUBLE:  pat_period = 11'(3 * T_SHORT_MS + T_LONG_OFF_MS);
            PAT_SINGLE:  pat_period = 11'(T_SHORT_MS + T_LONG_OFF_MS);
            PAT_FLICKER: pat_period = 11'(2 * T_FLICKER_MS);
            PAT_BLINK:   pat_period = 11'(2 * T_BLINK_MS);
            default:     pat_period = 11'd1;
        endcase
    endfunction : pat_period

    function automatic logic pat_on(input pslpg_pat_t p, input logic [PH_W-1:0] ph);
        unique case (p)
            PAT_ON:      pat_on = 1'b1;
            PAT_F1HZ:    pat_on = ph < T_FLASH_1HZ_MS;
            PAT_F5HZ:    pat_on = ph < T_FLASH_5HZ_MS;
            PAT_F2HZ:    pat_on = ph < T_SYS_ON_MS;
            PAT_TRIPLE:  pat_on = (ph < T_SHORT_MS)
                                  || (ph >= 11'(2 * T_SHORT_MS) && ph < 11'(3 * T_SHORT_MS))
                                  || (ph >= 11'(4 * T_SHORT_MS) && ph < 11'(5 * T_SHORT_MS));
            PAT_DOUBLE:  pat_on = (ph < T_SHORT_MS)
                                  || (ph >= 11'(2 * T_SHORT_MS) && ph < 11'(3 * T_SHORT_MS));
            PAT_SINGLE:  pat_on = ph < T_SHORT_MS;
            PAT_FLICKER: pat_on = ph < T_FLICKER_MS;
            PAT_BLINK:   pat_on = ph < T_BLINK_MS;
            default:     pat_on = 1'b0;
        endcase
    endfunction : pat_on

endpackage : pslpg_pkg

// ### src/pslpg_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes asynchronous inputs; the output changes once stages two and
 * three agree.
 */
module pslpg_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;
    logic [W-1:0] out_d;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q  <= din;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign dout = out_q;

endmodule : pslpg_sync

// ### src/pslpg_activity.sv
/*
 * Frame activity flicker for one Ethernet channel.
 * Assumes a synchronised activity level and a one-cycle millisecond tick
 * on the same clock.
 */
module pslpg_activity
    import pslpg_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic ms_tick,
    input  wire logic act_level,
    output logic      flick_on,
    output logic      busy
);
    typedef enum logic [1:0] {ACT_IDLE, ACT_ON, ACT_OFF} pslpg_act_t;

    pslpg_act_t       st_q, st_d;
    logic [ACT_W-1:0] cnt_q, cnt_d;
    logic             pend_q, pend_d;
    logic             lvl_q;
    logic             end_ph;

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        end_ph = ms_tick && (cnt_q == T_ACT_MS - 6'd1);
        // Frames seen during a flash keep the flicker going
        pend_d = pend_q | (act_level & ~lvl_q) | act_level;
        if (ms_tick) begin
            cnt_d = end_ph ? '0 : cnt_q + 6'd1;
        end
        unique case (st_q)
            ACT_IDLE: begin
                cnt_d = '0;
                if (pend_q) begin
                    st_d   = ACT_ON;
                    pend_d = act_level;
                end
            end
            ACT_ON: begin
                if (end_ph) begin
                    st_d = ACT_OFF;
                end
            end
            ACT_OFF: begin
                if (end_ph) begin
                    st_d   = pend_q ? ACT_ON : ACT_IDLE;
                    pend_d = act_level;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q   <= ACT_IDLE;
            cnt_q  <= '0;
            pend_q <= 1'b0;
            lvl_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            pend_q <= pend_d;
            lvl_q  <= act_level;
        end
    end

    assign flick_on = (st_q == ACT_ON);
    assign busy     = (st_q != ACT_IDLE);

endmodule : pslpg_activity

// ### src/pslpg_top.sv
/*
 * Protocol status LED pattern generator: registers on Avalon-MM, a
 * millisecond timebase, pattern sequencers for the two duo LEDs and the
 * per-channel link and activity LEDs.
 * Assumes link and activity inputs arrive from PHY pins asynchronously;
 * protocol state is written by software into the control register.
 */
// The Avalon-MM slave port and the register addresses are this design's own decisions.
module pslpg_top
    import pslpg_pkg::*;
#(
    parameter logic [PRESC_W-1:0] MS_CYCLES = MS_TICK_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic [1:0]        link_pin,
    input  wire logic [1:0]        act_pin,
    output logic                   status_led_green,
    output logic                   status_led_red,
    output logic                   error_led_green,
    output logic                   error_led_red,
    output logic      [1:0]        link_led,
    output logic      [1:0]        activity_indicator
);
    import pslpg_pkg::*;

    // Bus slave state
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] rdata_q, rdata_d;
    logic        wait_q, wait_d;
    logic [31:0] be_mask;

    // Timebase and pattern state
    logic [PRESC_W-1:0] presc_q, presc_d;
    logic               tick_q, tick_d;
    pslpg_pat_t         pat_a_q, pat_a_d, pat_b_q, pat_b_d;
    logic [PH_W-1:0]    ph_a_q, ph_a_d, ph_b_q, ph_b_d;

    // LED state
    logic       sg_q, sg_d, sr_q, sr_d, eg_q, eg_d, er_q, er_d;
    logic [1:0] link_q, link_d, act_q, act_d;

    logic [1:0] link_s, act_s, flick, busy;
    logic       mode_pl;
    logic [1:0] run_st;
    logic [2:0] node_st;

    pslpg_sync #(.W(4)) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .din    ({act_pin, link_pin}),
        .dout   ({act_s, link_s})
    );

    for (genvar c = 0; c < 2; c++) begin : g_act
        pslpg_activity u_act (
            .clk       (clk),
            .arst_n    (arst_n),
            .ms_tick   (tick_q),
            .act_level (act_s[c] & link_s[c]),
            .flick_on  (flick[c]),
            .busy      (busy[c])
        );
    end

    assign mode_pl = ctrl_q[CTRL_MODE];
    assign run_st  = ctrl_q[CTRL_RUN_LSB +: 2];
    assign node_st = ctrl_q[CTRL_NODE_LSB +: 3];

    // Avalon-MM slave: one wait cycle, then accept
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            be_mask[8*b +: 8] = {8{avs_byteenable[b]}};
        end
        ctrl_d  = ctrl_q;
        rdata_d = rdata_q;
        wait_d  = 1'b1;
        if ((avs_read || avs_write) && wait_q) begin
            wait_d = 1'b0;
            unique case (avs_address)
                OFS_CTRL:   rdata_d = ctrl_q;
                OFS_STATUS: rdata_d = {20'h0_0000, act_s, link_s, act_q, link_q,
                                       er_q, eg_q, sr_q, sg_q};
                default:    rdata_d = 32'h0000_0000;
            endcase
        end
        if (avs_write && !wait_q && avs_address == OFS_CTRL) begin
            ctrl_d = (ctrl_q & ~(be_mask & CTRL_WMASK))
                     | (avs_writedata & be_mask & CTRL_WMASK);
        end
    end

    always_comb begin
        tick_d  = (presc_q == MS_CYCLES - 18'd1);
        presc_d = tick_d ? '0 : presc_q + 18'd1;
    end

    // Pattern selection per mode
    always_comb begin
        pat_a_d = PAT_OFF;
        pat_b_d = PAT_OFF;
        if (!mode_pl) begin
            unique case (run_st)
                RUN_NOT_READY: pat_a_d = PAT_OFF;
                RUN_NOT_CFG:   pat_a_d = PAT_F1HZ;
                RUN_WAITING:   pat_a_d = PAT_F5HZ;
                RUN_CONNECTED: pat_a_d = PAT_ON;
            endcase
            if (ctrl_q[CTRL_SYSERR]) begin
                pat_b_d = PAT_F2HZ;
            end else if (ctrl_q[CTRL_COMERR]) begin
                pat_b_d = PAT_ON;
            end
        end else begin
            unique case (node_st)
                NODE_BASIC:   pat_a_d = PAT_FLICKER;
                NODE_PREOP1:  pat_a_d = PAT_SINGLE;
                NODE_PREOP2:  pat_a_d = PAT_DOUBLE;
                NODE_RTO:     pat_a_d = PAT_TRIPLE;
                NODE_OPER:    pat_a_d = PAT_ON;
                NODE_STOPPED: pat_a_d = PAT_BLINK;
                default:      pat_a_d = PAT_OFF;
            endcase
            pat_b_d = ctrl_q[CTRL_NODEERR] ? PAT_ON : PAT_OFF;
        end
    end

    always_comb begin
        ph_a_d = ph_a_q;
        ph_b_d = ph_b_q;
        if (pat_a_d != pat_a_q) begin
            ph_a_d = '0;
        end else if (tick_q) begin
            ph_a_d = (ph_a_q + 11'd1 >= pat_period(pat_a_q)) ? '0 : ph_a_q + 11'd1;
        end
        if (pat_b_d != pat_b_q) begin
            ph_b_d = '0;
        end else if (tick_q) begin
            ph_b_d = (ph_b_q + 11'd1 >= pat_period(pat_b_q)) ? '0 : ph_b_q + 11'd1;
        end
    end

    // LED drive
    always_comb begin
        sg_d = pat_on(pat_a_q, ph_a_q);
        sr_d = mode_pl && (pat_a_q == PAT_FLICKER || pat_a_q == PAT_BLINK)
               && !pat_on(pat_a_q, ph_a_q);
        eg_d = 1'b0;
        er_d = pat_on(pat_b_q, ph_b_q);
        for (int c = 0; c < 2; c++) begin
            if (!mode_pl) begin
                link_d[c] = link_s[c];
                act_d[c]  = flick[c];
            end else begin
                link_d[c] = link_s[c] && (!busy[c] || flick[c]);
                act_d[c]  = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q  <= CTRL_RESET;
            rdata_q <= 32'h0000_0000;
            wait_q  <= 1'b1;
            presc_q <= '0;
            tick_q  <= 1'b0;
            pat_a_q <= PAT_OFF;
            pat_b_q <= PAT_OFF;
            ph_a_q  <= '0;
            ph_b_q  <= '0;
            sg_q    <= 1'b0;
            sr_q    <= 1'b0;
            eg_q    <= 1'b0;
            er_q    <= 1'b0;
            link_q  <= 2'h0;
            act_q   <= 2'h0;
        end else begin
            ctrl_q  <= ctrl_d;
            rdata_q <= rdata_d;
            wait_q  <= wait_d;
            presc_q <= presc_d;
            tick_q  <= tick_d;
            pat_a_q <= pat_a_d;
            pat_b_q <= pat_b_d;
            ph_a_q  <= ph_a_d;
            ph_b_q  <= ph_b_d;
            sg_q    <= sg_d;
            sr_q    <= sr_d;
            eg_q    <= eg_d;
            er_q    <= er_d;
            link_q  <= link_d;
            act_q   <= act_d;
        end
    end

    assign avs_readdata       = rdata_q;
    assign avs_waitrequest    = wait_q;
    assign status_led_green   = sg_q;
    assign status_led_red     = sr_q;
    assign error_led_green    = eg_q;
    assign error_led_red      = er_q;
    assign link_led           = link_q;
    assign activity_indicator = act_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    AST_MB_CONNECTED: assert property (
        !mode_pl && run_st == RUN_CONNECTED |-> ##2 sg_q && !sr_q)
        else $error("run LED not steady green while connected");
    AST_MB_NOT_READY: assert property (
        !mode_pl && run_st == RUN_NOT_READY |-> ##2 !sg_q && !sr_q)
        else $error("run LED lit while task not ready");
    AST_MB_SLOW_FLASH: assert property (
        pat_a_q == PAT_F1HZ && (ph_a_q == 11'd499 || ph_a_q == 11'd500)
        |=> sg_q == ($past(ph_a_q) == 11'd499))
        else $error("1 Hz flash on phase wrong");
    AST_MB_FAST_FLASH: assert property (
        pat_a_q == PAT_F5HZ && ph_a_q == 11'd150 |=> !sg_q)
        else $error("5 Hz flash lit in off phase");
    AST_ERR_COMM: assert property (
        !mode_pl && ctrl_q[CTRL_COMERR] && !ctrl_q[CTRL_SYSERR] |-> ##2 er_q && !eg_q)
        else $error("comm error not steady red");
    AST_SYS_DUTY: assert property (
        pat_b_q == PAT_F2HZ && ph_b_q == 11'd125 |=> !er_q)
        else $error("system error flash on past 125 ms");
    AST_TRIPLE_THIRD: assert property (
        pat_a_q == PAT_TRIPLE && ph_a_q == 11'd900 |=> sg_q)
        else $error("third flash missing");
    AST_DOUBLE_GAP: assert property (
        pat_a_q == PAT_DOUBLE && (ph_a_q == 11'd300 || ph_a_q == 11'd800) |=> !sg_q)
        else $error("double flash lit in gap");
    AST_SINGLE_PERIOD: assert property (
        ph_a_q < pat_period(pat_a_q))
        else $error("phase beyond pattern period");
    AST_DUO_ALTERNATE: assert property (
        !(sg_q && sr_q))
        else $error("red and green lit together");
    AST_BLINK_RED: assert property (
        pat_a_q == PAT_BLINK && ph_a_q == 11'd300 && mode_pl |=> sr_q && !sg_q)
        else $error("blink off phase not red");
    AST_NODE_ERR: assert property (
        mode_pl && ctrl_q[CTRL_NODEERR] |-> ##2 er_q)
        else $error("node error not shown red");
    AST_NO_YELLOW: assert property (
        mode_pl |=> act_q == 2'h0)
        else $error("yellow LED lit in node mode");
    AST_MB_LINK: assert property (
        !mode_pl && !$past(mode_pl) && !link_s[0] |=> !link_q[0])
        else $error("link LED on without link");
    AST_RESTART: assert property (
        pat_a_d != pat_a_q |=> ph_a_q == 11'd0 && $past(pat_a_d) == pat_a_q)
        else $error("pattern did not restart");
    AST_BUS_ONE_ACK: assert property (
        !wait_q |=> wait_q)
        else $error("waitrequest low for more than one cycle");

    COV_TRIPLE: cover property (pat_a_q == PAT_TRIPLE && ph_a_q == 11'd1999);
    COV_FLICKER_RED: cover property (pat_a_q == PAT_FLICKER && sr_q);
    COV_SYS_ERR: cover property (pat_b_q == PAT_F2HZ && $fell(er_q));
    COV_ACT: cover property (act_q[0] && !mode_pl);

endmodule : pslpg_top

// ### test/pslpg_phy_model.sv
/*
 * Far-side model: PHY link and activity levels for both channels.
 * Assumes the bench sets the requested levels; pins move on clock edges.
 */
module pslpg_phy_model (
    input  wire logic       clk,
    input  wire logic [1:0] link_req,
    input  wire logic [1:0] act_req,
    output logic      [1:0] link_pin,
    output logic      [1:0] act_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    // Frames only move on a linked port
    always @(posedge clk) begin
        link_pin <= link_req;
        act_pin  <= act_req & link_req;
    end
endmodule : pslpg_phy_model

// ### test/pslpg_tb_top.sv
/*
 * Testbench: Avalon-MM register tasks, LED pattern measurement by
 * on-cycle counts over whole periods.
 * Assumes a one-wait-cycle slave and a 4-cycle millisecond tick.
 */
module pslpg_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import pslpg_pkg::*;

    localparam int MS = 4;
    typedef struct {int ctrl; int lk; int ac; int win; int g; int r; int e; int rs; int ll; int ai;}
        pslpg_case_t;

    logic              clk = 1'b0;
    logic              arst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [31:0]       avs_writedata = 32'h0;
    logic [3:0]        avs_byteenable = 4'hf;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic [1:0]        link_req = 2'h0;
    logic [1:0]        act_req = 2'h0;
    logic [1:0]        link_pin;
    logic [1:0]        act_pin;
    logic              sg, sr, eg, er;
    logic [1:0]        link_led;
    logic [1:0]        activity_indicator;
    int                n_mismatch = 0;
    int                n_tests = 0;
    int                cyc = 0;
    logic [31:0]       rd;
    pslpg_case_t       cases [19] = '{
        '{'h000,0,0, 200,  0,  0,  0,0,  0,  0}, // idle
        '{'h004,0,0,1000,500,  0,  0,1,  0,  0}, // 1 Hz
        '{'h008,0,0, 200,100,  0,  0,1,  0,  0}, // 5 Hz
        '{'h00c,0,0, 200,200,  0,  0,0,  0,  0}, // steady
        '{'h01c,0,0, 500,500,  0,125,0,  0,  0}, // system error
        '{'h02c,0,0, 200,200,  0,200,0,  0,  0}, // comm error
        '{'h03c,0,0, 500,500,  0,125,0,  0,  0}, // priority
        '{'h00c,1,0, 200,200,  0,  0,0,400,  0}, // link
        '{'h00c,1,1, 100,100,  0,  0,0,200,100}, // activity
        '{'h001,0,0, 200,  0,  0,  0,0,  0,  0}, // init
        '{'h501,0,0, 200,200,  0,  0,0,  0,  0}, // operational
        '{'h401,0,0,2000,600,  0,  0,3,  0,  0}, // triple
        '{'h301,0,0,1600,400,  0,  0,2,  0,  0}, // double
        '{'h201,0,0,1200,200,  0,  0,1,  0,  0}, // single
        '{'h101,0,0, 100, 50, 50,  0,1,  0,  0}, // flicker
        '{'h601,0,0, 400,200,200,  0,1,  0,  0}, // blink
        '{'h1501,0,0,200,200,  0,200,0,  0,  0}, // node error
        '{'h501,1,0, 200,200,  0,  0,0,400,  0}, // linked idle
        '{'h501,1,1, 100,100,  0,  0,0,100,  0}  // traffic
    };

    always #2.5 clk = ~clk;

    pslpg_phy_model phy (
        .clk      (clk),
        .link_req (link_req),
        .act_req  (act_req),
        .link_pin (link_pin),
        .act_pin  (act_pin)
    );

    pslpg_top #(.MS_CYCLES(PRESC_W'(MS))) dut (
        .clk                (clk),
        .arst_n             (arst_n),
        .avs_address        (avs_address),
        .avs_read           (avs_read),
        .avs_write          (avs_write),
        .avs_writedata      (avs_writedata),
        .avs_byteenable     (avs_byteenable),
        .avs_readdata       (avs_readdata),
        .avs_waitrequest    (avs_waitrequest),
        .link_pin           (link_pin),
        .act_pin            (act_pin),
        .status_led_green   (sg),
        .status_led_red     (sr),
        .error_led_green    (eg),
        .error_led_red      (er),
        .link_led           (link_led),
        .activity_indicator (activity_indicator)
    );

    task automatic results;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic measure(input pslpg_case_t c);
        int g, r, e, rs, ll, ai, eg_on;
        logic prev;
        g = 0; r = 0; e = 0; rs = 0; ll = 0; ai = 0; eg_on = 0;
        prev = sg;
        repeat (c.win * MS) begin
            @(posedge clk);
            g += int'(sg);
            r += int'(sr);
            e += int'(er);
            eg_on += int'(eg);
            rs += int'(sg & ~prev);
            prev = sg;
            ll += $countones(link_led);
            ai += $countones(activity_indicator);
        end
        chk(32'(g), 32'(c.g * MS));   // green count
        chk(32'(r), 32'(c.r * MS));   // red alternates
        chk(32'(e), 32'(c.e * MS));   // error red
        chk(32'(eg_on), 32'h0);       // error green unused
        chk(32'(rs), 32'(c.rs));      // flash count
        chk(32'(ll), 32'(c.ll * MS)); // link
        chk(32'(ai), 32'(c.ai * MS)); // activity
    endtask : measure

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h0);                         // control reset value
        bus(1'b1, OFS_CTRL, 32'hffff_ffff);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(rd, CTRL_WMASK);                    // writable bits only
        bus(1'b0, 4'h8, 32'h0);
        chk(rd, 32'h0);                         // unmapped reads zero
        foreach (cases[i]) begin
            link_req <= {2{cases[i].lk[0]}};
            act_req  <= {2{cases[i].ac[0]}};
            bus(1'b1, OFS_CTRL, 32'(cases[i].ctrl));
            repeat (10 * MS) @(posedge clk);
            measure(cases[i]);                  // LED on-cycle and flash counts
        end
        // Mid-run reset, then status and refused writes
        link_req <= 2'h0;
        act_req  <= 2'h0;
        arst_n   <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(rd, CTRL_RESET);                    // reset clears control
        bus(1'b1, OFS_CTRL, 32'h0000_000c);
        bus(1'b1, OFS_STATUS, 32'hffff_ffff);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h0000_000c);                 // status write ignored
        repeat (10 * MS) @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0000_0001);                 // status shows steady green
        results();
    end
endmodule : pslpg_tb_top
